// >>> design/dcs_map.svh
// Register field positions, reset values, commands and timing counts for the debug control block
`ifndef DCS_MAP_SVH
`define DCS_MAP_SVH
`define DCS_CTL_DEBUG_BIT 7
`define DCS_CTL_BRK_EN_BIT 6
`define DCS_CTL_ACK_EN_BIT 5
`define DCS_CTL_RESET_BIT 0
`define DCS_STAT_DEBUG_BIT 7
`define DCS_STAT_HALT_BIT 6
`define DCS_STAT_RPI_BIT 5
`define DCS_CTL_RESET_VAL 8'h00
`define DCS_STAT_RESET_VAL 8'h00
`define DCS_CMD_RD_STAT 8'h02
`define DCS_CMD_WR_CTL 8'h04
`define DCS_CMD_RD_CTL 8'h05
`define DCS_ACK_CHAR 8'hFF
`define DCS_BRK_OPCODE 8'h00
`define DCS_RESET_NS 100
`define DCS_CLK_MHZ 100
`define DCS_RESET_CYC ((`DCS_RESET_NS * `DCS_CLK_MHZ + 999) / 1000)
`endif

// >>> design/dcs_pkg.sv
// Types shared by the debug control block
package dcs_pkg;
  typedef enum logic [2:0] {
    DCS_IDLE = 3'b001,
    DCS_WAIT_DATA = 3'b010,
    DCS_REPLY = 3'b100
  } dcs_cmd_state_t;
endpackage

// >>> design/dcs_sys_reset.sv
// Timed system reset pulse requested by the debugger
`include "dcs_map.svh"
module dcs_sys_reset (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  output logic sys_reset,
  output logic done
);
  logic [7:0] cnt_r;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 8'h00;
      sys_reset <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !sys_reset) begin
        sys_reset <= 1'b1;
        cnt_r <= 8'((`DCS_RESET_CYC) - 1);
      end else if (sys_reset) begin
        if (cnt_r == 8'h00) begin
          sys_reset <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
      end
    end
  end
endmodule // dcs_sys_reset

// >>> design/dcs_regs.sv
// Debugger control and status registers with command decoding
//
// Behaviour
// - Control bit 7 set means debug state
// - Debug state stops CPU instruction fetch
// - Clearing debug bit resumes CPU execution
// - Enabled breakpoint opcode sets debug bit
// - Read protection blocks clearing the debug bit
// - Bit 6 selects breakpoint or no-operation
// - Bit 5 sends FFH on breakpoint
// - Reserved bits read zero, not writable
// - Bit 0 resets device, debugger kept
// - Reset bit self-clears when reset ends
// - Status bit 7 shows debug state
// - Status bit 6 shows CPU halt
// - Status bit 5 low when protection active
// - Command 04H plus byte writes control
// - Command 05H returns control byte
// - Command 02H returns status byte
// - 81H, 41H, 40H give reset/run controls
`include "dcs_map.svh"
module dcs_regs (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_valid,
  input wire logic tx_ready,
  input wire logic brk_decoded,
  input wire logic cpu_halted,
  input wire logic flash_read_protect,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  output logic fetch_stall,
  output logic brk_as_nop,
  output logic sys_reset,
  output logic debug_state_flag
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  dcs_pkg::dcs_cmd_state_t state_r;
  logic debug_state_bit_r;
  logic breakpoint_enable_r;
  logic breakpoint_ack_enable_r;
  logic self_reset_r;
  logic halt_s1_r;
  logic halt_s2_r;
  logic frp_s1_r;
  logic frp_s2_r;
  logic ack_pend_r;
  logic rst_done;
  logic rst_pulse;
  logic brk_take;
  logic wr_ctl;
  logic [7:0] ctl_val;
  logic [7:0] stat_val;

  // Same match for every command byte taken in the idle state
  function automatic logic is_cmd(input logic valid, input logic [7:0] byte_in, input logic [7:0] code);
    return valid && (byte_in == code);
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Protection and halt arrive from other logic domains
  // A fresh protection level guards control writes two cycles late
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      halt_s1_r <= 1'b0;
      halt_s2_r <= 1'b0;
      frp_s1_r <= 1'b0;
      frp_s2_r <= 1'b0;
    end else begin
      halt_s1_r <= cpu_halted;
      halt_s2_r <= halt_s1_r;
      frp_s1_r <= flash_read_protect;
      frp_s2_r <= frp_s1_r;
    end
  end

  // ----------------------------------------
  // Register read views
  // ----------------------------------------
  // Reserved fields are constant zero, so writes to them go nowhere
  // Both views are rebuilt every cycle from live state; a reply holds the byte sampled when its command was taken
  always_comb begin
    ctl_val = `DCS_CTL_RESET_VAL;
    ctl_val[`DCS_CTL_DEBUG_BIT] = debug_state_bit_r;
    ctl_val[`DCS_CTL_BRK_EN_BIT] = breakpoint_enable_r;
    ctl_val[`DCS_CTL_ACK_EN_BIT] = breakpoint_ack_enable_r;
    ctl_val[`DCS_CTL_RESET_BIT] = self_reset_r;
    stat_val = `DCS_STAT_RESET_VAL;
    stat_val[`DCS_STAT_DEBUG_BIT] = debug_state_bit_r;
    stat_val[`DCS_STAT_HALT_BIT] = halt_s2_r;
    stat_val[`DCS_STAT_RPI_BIT] = !frp_s2_r;
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  assign wr_ctl = (state_r == dcs_pkg::DCS_WAIT_DATA) && cmd_valid;
  assign brk_take = brk_decoded && breakpoint_enable_r && !debug_state_bit_r;
  assign rst_pulse = wr_ctl && cmd_byte[`DCS_CTL_RESET_BIT];

  // ----------------------------------------
  // Reply and acknowledge
  // ----------------------------------------
  // Host commands go first; a pending acknowledge waits for an idle cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= dcs_pkg::DCS_IDLE;
      tx_byte <= 8'h00;
      tx_valid <= 1'b0;
      ack_pend_r <= 1'b0;
    end else begin
      if (brk_take && breakpoint_ack_enable_r) begin
        ack_pend_r <= 1'b1;
      end
      case (state_r)
        dcs_pkg::DCS_IDLE: begin
          if (is_cmd(cmd_valid, cmd_byte, `DCS_CMD_WR_CTL)) begin
            state_r <= dcs_pkg::DCS_WAIT_DATA;
          end else if (is_cmd(cmd_valid, cmd_byte, `DCS_CMD_RD_CTL)) begin
            tx_byte <= ctl_val;
            tx_valid <= 1'b1;
            state_r <= dcs_pkg::DCS_REPLY;
          end else if (is_cmd(cmd_valid, cmd_byte, `DCS_CMD_RD_STAT)) begin
            tx_byte <= stat_val;
            tx_valid <= 1'b1;
            state_r <= dcs_pkg::DCS_REPLY;
          end else if (ack_pend_r) begin
            tx_byte <= `DCS_ACK_CHAR;
            tx_valid <= 1'b1;
            ack_pend_r <= brk_take && breakpoint_ack_enable_r;
            state_r <= dcs_pkg::DCS_REPLY;
          end
        end
        dcs_pkg::DCS_WAIT_DATA: begin
          if (cmd_valid) begin
            state_r <= dcs_pkg::DCS_IDLE;
          end
        end
        dcs_pkg::DCS_REPLY: begin
          if (tx_ready) begin
            tx_valid <= 1'b0;
            state_r <= dcs_pkg::DCS_IDLE;
          end
        end
        default: state_r <= dcs_pkg::DCS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // Only the pin reset clears these; the self-reset drives sys_reset outward only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      debug_state_bit_r <= 1'b0;
      breakpoint_enable_r <= 1'b0;
      breakpoint_ack_enable_r <= 1'b0;
    end else begin
      if (wr_ctl) begin
        breakpoint_enable_r <= cmd_byte[`DCS_CTL_BRK_EN_BIT];
        breakpoint_ack_enable_r <= cmd_byte[`DCS_CTL_ACK_EN_BIT];
      end
      // Breakpoint set wins over a simultaneous clear
      if (brk_take) begin
        debug_state_bit_r <= 1'b1;
      end else if (wr_ctl && (cmd_byte[`DCS_CTL_DEBUG_BIT] || !frp_s2_r)) begin
        debug_state_bit_r <= cmd_byte[`DCS_CTL_DEBUG_BIT];
      end
    end
  end

  // ----------------------------------------
  // Self-reset request
  // ----------------------------------------
  // The bit reads one for the whole timed reset and drops the cycle after it ends
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      self_reset_r <= 1'b0;
    end else if (rst_pulse) begin
      self_reset_r <= 1'b1;
    end else if (rst_done) begin
      self_reset_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // CPU side outputs
  // ----------------------------------------
  // Stall also in the breakpoint cycle, before the debug bit is visible
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_stall <= 1'b0;
      brk_as_nop <= 1'b1;
      debug_state_flag <= 1'b0;
    end else begin
      fetch_stall <= debug_state_bit_r || brk_take;
      brk_as_nop <= !breakpoint_enable_r;
      debug_state_flag <= debug_state_bit_r;
    end
  end

  // ----------------------------------------
  // System reset timer
  // ----------------------------------------
  // The timer clears only by pin reset, so it survives its own pulse
  dcs_sys_reset u_sys_reset (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(rst_pulse),
    .sys_reset(sys_reset),
    .done(rst_done)
  );
endmodule // dcs_regs

// >>> tb/dcs_host.sv
// Host debugger model driving command bytes and taking replies
module dcs_host (
  input wire logic mclk,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] cmd_byte,
  output logic cmd_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    tx_ready = 1'b0;
    cmd_byte = 8'h00;
    cmd_valid = 1'b0;
  end
  // Random stalls so a reply must hold until taken
  always @(posedge mclk) tx_ready <= tx_valid && $urandom_range(0, 2) != 0;
  task automatic send(input logic [7:0] b);
    @(posedge mclk);
    cmd_byte <= b;
    cmd_valid <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd_byte <= ~b;
  endtask
endmodule  // dcs_host

// >>> tb/dcs_regs_properties.sv
// Timing checks on the debugger control and status block ports
module dcs_regs_properties (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_valid,
  input wire logic tx_ready,
  input wire logic brk_decoded,
  input wire logic cpu_halted,
  input wire logic flash_read_protect,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  input wire logic fetch_stall,
  input wire logic brk_as_nop,
  input wire logic sys_reset,
  input wire logic debug_state_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_pend_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Marks a data byte so it is not taken for a read command
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) wr_pend_r <= 1'b0;
    else if (cmd_valid) wr_pend_r <= !wr_pend_r && cmd_byte == 8'h04;
  end
  debug_stall_a: assert property (debug_state_flag |-> fetch_stall) else $error("no stall");
  brk_entry_a: assert property ((brk_decoded && !brk_as_nop) ##1 !brk_as_nop |=> debug_state_flag)
    else $error("no entry");
  brk_nop_a: assert property ((brk_decoded && brk_as_nop) ##1 brk_as_nop |-> fetch_stall == debug_state_flag)
    else $error("nop entered debug");
  protect_hold_a: assert property ((debug_state_flag && flash_read_protect) [*4] |=> debug_state_flag)
    else $error("debug cleared");
  reset_len_a: assert property ($rose(sys_reset) |-> sys_reset [*8] ##1 sys_reset ##1 sys_reset
    ##1 !sys_reset) else $error("reset length");
  reply_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte)) else $error("reply lost");
  read_answer_a: assert property (cmd_valid && !wr_pend_r && !tx_valid &&
    (cmd_byte == 8'h05 || cmd_byte == 8'h02) |=> tx_valid) else $error("no reply");
  reset_vals_a: assert property ($rose(rst_n) |-> !debug_state_flag && !sys_reset && !tx_valid)
    else $error("reset value");
endmodule  // dcs_regs_properties
bind dcs_regs dcs_regs_properties chk (.mclk(mclk), .rst_n(rst_n), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid),
  .tx_ready(tx_ready), .brk_decoded(brk_decoded), .cpu_halted(cpu_halted), .flash_read_protect(flash_read_protect),
  .tx_byte(tx_byte), .tx_valid(tx_valid), .fetch_stall(fetch_stall), .brk_as_nop(brk_as_nop),
  .sys_reset(sys_reset), .debug_state_flag(debug_state_flag));

// >>> tb/debug_control_status_regs_test.sv
// Self-checking bench for the debugger control and status block
module debug_control_status_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst_n, brk_decoded, cpu_halted, flash_read_protect, h;
  logic cmd_valid, tx_ready, tx_valid, fetch_stall, brk_as_nop, sys_reset, debug_state_flag;
  logic [7:0] cmd_byte, tx_byte;
  logic [7:0] exp_q[$];
  int errors = 0;
  int n_tests = 0;
  dcs_regs uut (.mclk(mclk), .rst_n(rst_n), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid), .tx_ready(tx_ready),
    .brk_decoded(brk_decoded), .cpu_halted(cpu_halted), .flash_read_protect(flash_read_protect),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .fetch_stall(fetch_stall), .brk_as_nop(brk_as_nop),
    .sys_reset(sys_reset), .debug_state_flag(debug_state_flag));
  dcs_host host (.mclk(mclk), .tx_valid(tx_valid), .tx_ready(tx_ready), .cmd_byte(cmd_byte), .cmd_valid(cmd_valid));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
    n_tests++;
    if (exp_q.size() == 0 || tx_byte !== exp_q.pop_front()) begin
      errors++;
      $display("unexpected at %0t: reply %h", $time, tx_byte);
    end
  end
  task automatic check(input logic ok);
    n_tests++;
    if (ok !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: output mismatch", $time);
    end
  endtask
  // Next request only once any reply has been taken
  task automatic idle();
    @(posedge mclk);
    for (int i = 0; i < 60 && tx_valid !== 1'b0; i++) @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    exp_q.push_back(e);
    host.send(c);
    idle();
  endtask
  task automatic wr(input logic [7:0] d);
    host.send(8'h04);
    host.send(d);
    repeat (2) @(posedge mclk);
  endtask
  task automatic breakpoint_opcode();
    brk_decoded <= 1'b1;
    @(posedge mclk);
    brk_decoded <= 1'b0;
    repeat (3) idle();
  endtask
  task automatic final_report();
    $display("Comparisons %0d, errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #20us;
    errors++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    brk_decoded = 1'b0;
    cpu_halted = 1'b0;
    flash_read_protect = 1'b0;
    void'($urandom(81));
    h = 1'($urandom_range(0, 1));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'h05, 8'h00);
    rd(8'h02, 8'h20);
    cpu_halted <= h;
    wr(8'hFE);
    check(fetch_stall === 1'b1 && debug_state_flag === 1'b1);
    rd(8'h05, 8'hE0);
    rd(8'h02, {1'b1, h, 6'h20});
    wr(8'h40);
    check(fetch_stall === 1'b0 && brk_as_nop === 1'b0);
    wr(8'h60);
    exp_q.push_back(8'hFF);
    breakpoint_opcode();
    breakpoint_opcode();
    rd(8'h05, 8'hE0);
    wr(8'h00);
    breakpoint_opcode();
    check(debug_state_flag === 1'b0 && brk_as_nop === 1'b1);
    flash_read_protect <= 1'b1;
    wr(8'h80);
    wr(8'h00);
    rd(8'h02, {1'b1, h, 6'h00});
    wr(8'h81);
    check(sys_reset === 1'b1);
    repeat (12) @(posedge mclk);
    rd(8'h05, 8'h80);
    flash_read_protect <= 1'b0;
    repeat (4) @(posedge mclk);
    wr(8'h41);
    check(debug_state_flag === 1'b0 && sys_reset === 1'b1);
    repeat (12) @(posedge mclk);
    rd(8'h05, 8'h40);
    check(exp_q.size() == 0);
    final_report();
  end
endmodule  // debug_control_status_regs_test
